/* File: core/lsr_top.sv */
/*
  Line status readback registers behind a classic Wishbone slave: noise
  margin, coefficient word bytes, training substate and combined gain and
  activation state, plus the coefficient select and a mode control word.
  Assumes all inputs are synchronous to core_clk, baud_tick is a one-cycle
  pulse per baud, and the datapath returns the selected coefficient on
  coef_word_in.
*/
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`include "lsr_params.svh"

// Functional notes
// - noise margin reads as an 8-bit two's-complement count of half decibels.
// - the coefficient word holds the coefficient named by the last value written to coefficient select.
// - the coefficient word is refreshed on each rising edge of the receive symbol clock.
// - the coefficient word reads as low byte at index 3 and high byte at index 4.
// - in central-office mode substates 1 to 8 code pre-gain through frame detect.
// - in remote-terminal mode substates 1 to 7 code wait through frame detect, 8 unused.
// - the substate reads zero unless the activation state is activating.
// - activation state bits 2, 1, 0 sit at b7, b6 and b3 of the combined register.
// - b5-b4 of the combined register hold the digital gain step, gain two to the n.
// - b2-b0 of the combined register hold the analog gain step, -12 dB plus 2 dB per code.
// - the gain fields mirror the digital setting and the analog front end report.
// - noise margin is readable always but reloaded only once per 64 baud intervals.
// - activation state codes 0 to 5 are inactive to deactivated, 6 and 7 unused.
module lsr_top
#(
  parameter int NM_BAUDS = `LSR_NM_BAUDS
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic baud_tick,
  input wire logic [7:0] noise_margin_calc,
  input wire logic receive_symbol_clock,
  input wire logic [15:0] coef_word_in,
  output logic [7:0] coefficient_select,
  input wire lsr_pkg::lsr_act_state_t act_state,
  input wire lsr_pkg::lsr_phase_t train_phase,
  input wire logic [1:0] digital_gain_setting,
  input wire logic [2:0] analog_gain_step,
  output logic rt_mode
);
  import lsr_pkg::*;

  localparam int NM_W = $clog2(NM_BAUDS + 1);

  // map a training phase to its substate code for the selected mode
  function automatic logic [3:0] substate_code(input lsr_phase_t ph, input logic rt);
    logic [3:0] code;
    code = `LSR_SUB_NONE;
    if (rt)
    begin
      unique case (ph)
        LSR_PH_WAIT: code = `LSR_SUB_1;
        LSR_PH_GAIN_ADAPT: code = `LSR_SUB_2;
        LSR_PH_ECHO_CANCEL: code = `LSR_SUB_3;
        LSR_PH_FIRST_LOCK: code = `LSR_SUB_4;
        LSR_PH_SECOND_LOCK: code = `LSR_SUB_5;
        LSR_PH_FOUR_LEVEL_DETECT: code = `LSR_SUB_6;
        LSR_PH_FRAME_DETECT: code = `LSR_SUB_7;
        default: code = `LSR_SUB_NONE;
      endcase
    end
    else
    begin
      unique case (ph)
        LSR_PH_PRE_GAIN: code = `LSR_SUB_1;
        LSR_PH_PRE_ECHO_CANCEL: code = `LSR_SUB_2;
        LSR_PH_SIGNAL_DETECT: code = `LSR_SUB_3;
        LSR_PH_GAIN_ADAPT: code = `LSR_SUB_4;
        LSR_PH_ECHO_CANCEL: code = `LSR_SUB_5;
        LSR_PH_FIRST_LOCK: code = `LSR_SUB_6;
        LSR_PH_SECOND_LOCK: code = `LSR_SUB_6;
        LSR_PH_FOUR_LEVEL_DETECT: code = `LSR_SUB_7;
        LSR_PH_FRAME_DETECT: code = `LSR_SUB_8;
        default: code = `LSR_SUB_NONE;
      endcase
    end
    return code;
  endfunction

  // place a byte in the low lane of a bus word
  function automatic logic [31:0] lane0(input logic [7:0] b);
    return {24'h000000, b};
  endfunction

  lsr_coef_if cif();

  lsr_bus_state_t bus_reg;
  lsr_bus_state_t bus_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [7:0] sel_reg;
  logic [7:0] sel_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] nm_reg;
  logic [7:0] nm_next;
  logic [NM_W-1:0] baud_cnt_reg;
  logic [NM_W-1:0] baud_cnt_next;
  logic [7:0] sub_reg;
  logic [7:0] sub_next;
  logic [7:0] gs_reg;
  logic [7:0] gs_next;
  logic rsc_reg;
  logic [3:0] idx;
  logic req;

  assign idx = wb_adr_i[5:2];
  assign req = wb_cyc_i && wb_stb_i && (bus_reg == LSR_BUS_IDLE);

  // bus slave: one wait-free ack cycle, then back to idle
  always_comb
  begin
    bus_next = bus_reg;
    unique case (bus_reg)
      LSR_BUS_IDLE:
      begin
        if (wb_cyc_i && wb_stb_i)
        begin
          bus_next = LSR_BUS_ACK;
        end
      end
      LSR_BUS_ACK:
      begin
        bus_next = LSR_BUS_IDLE;
      end
      default:
      begin
        bus_next = LSR_BUS_IDLE;
      end
    endcase
  end

  // read mux; reads only copy values out, nothing is cleared
  always_comb
  begin
    rdata_next = rdata_reg;
    if (req && !wb_we_i)
    begin
      unique case (idx)
        `LSR_IDX_NOISE_MARGIN: rdata_next = lane0(nm_reg);
        `LSR_IDX_COEF_LOW: rdata_next = lane0(cif.low_byte);
        `LSR_IDX_COEF_HIGH: rdata_next = lane0(cif.high_byte);
        `LSR_IDX_TRAIN_SUBSTATE: rdata_next = lane0(sub_reg);
        `LSR_IDX_GAIN_STATE: rdata_next = lane0(gs_reg);
        `LSR_IDX_CONTROL: rdata_next = lane0(ctrl_reg);
        default: rdata_next = 32'h00000000; // unmapped reads zero
      endcase
    end
  end

  // low-byte read takes the high-byte snapshot in the same edge
  assign cif.low_read = req && !wb_we_i && (idx == `LSR_IDX_COEF_LOW);

  // writable words; writes to status indices fall through untouched
  always_comb
  begin
    sel_next = sel_reg;
    ctrl_next = ctrl_reg;
    if (req && wb_we_i && wb_sel_i[0])
    begin
      if (idx == `LSR_IDX_COEF_SELECT)
      begin
        sel_next = wb_dat_i[7:0];
      end
      else if (idx == `LSR_IDX_CONTROL)
      begin
        ctrl_next = wb_dat_i[7:0];
      end
    end
  end

  // noise margin reload every NM_BAUDS baud ticks; held value in between
  always_comb
  begin
    baud_cnt_next = baud_cnt_reg;
    nm_next = nm_reg;
    if (baud_tick)
    begin
      if (baud_cnt_reg == NM_W'(NM_BAUDS - 1))
      begin
        baud_cnt_next = '0;
        nm_next = noise_margin_calc;
      end
      else
      begin
        baud_cnt_next = baud_cnt_reg + NM_W'(1);
      end
    end
  end

  // substate forced to zero outside the activating state
  always_comb
  begin
    sub_next = 8'h00;
    if (act_state == LSR_ACT_ACTIVATING)
    begin
      sub_next = {4'h0, substate_code(train_phase, ctrl_reg[`LSR_CTRL_RT_MODE])};
    end
  end

  // combined gain and activation state word
  always_comb
  begin
    gs_next = 8'h00;
    gs_next[`LSR_GS_ST2] = act_state[2];
    gs_next[`LSR_GS_ST1] = act_state[1];
    gs_next[`LSR_GS_ST0] = act_state[0];
    gs_next[`LSR_GS_DG_HI:`LSR_GS_DG_LO] = digital_gain_setting;
    gs_next[`LSR_GS_AG_HI:`LSR_GS_AG_LO] = analog_gain_step;
  end

  // symbol clock is sampled as a plain synchronous input; capture on rise
  assign cif.capture = receive_symbol_clock && !rsc_reg;
  assign cif.word_in = coef_word_in;

  // bus state and read data; read data stays put between reads
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      bus_reg <= LSR_BUS_IDLE;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      bus_reg <= bus_next;
      rdata_reg <= rdata_next;
    end
  end

  // host-written words: coefficient select and mode control
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sel_reg <= `LSR_RST_COEF_SELECT;
      ctrl_reg <= `LSR_RST_CONTROL;
    end
    else
    begin
      sel_reg <= sel_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // noise margin and its baud counter; the count restarts with reset
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      nm_reg <= `LSR_RST_BYTE;
      baud_cnt_reg <= '0;
    end
    else
    begin
      nm_reg <= nm_next;
      baud_cnt_reg <= baud_cnt_next;
    end
  end

  // status sampling, one cycle behind the inputs
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sub_reg <= `LSR_RST_BYTE;
      gs_reg <= `LSR_RST_BYTE;
    end
    else
    begin
      sub_reg <= sub_next;
      gs_reg <= gs_next;
    end
  end

  // last symbol clock sample for the rise detector; reset low, so a
  // symbol clock already high at release gives one early capture
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rsc_reg <= 1'b0;
    end
    else
    begin
      rsc_reg <= receive_symbol_clock;
    end
  end

  lsr_coef_store u_store
  (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .cif(cif.store)
  );

  // outputs
  assign wb_ack_o = (bus_reg == LSR_BUS_ACK);
  assign wb_dat_o = rdata_reg;
  assign coefficient_select = sel_reg;
  assign rt_mode = ctrl_reg[`LSR_CTRL_RT_MODE];
endmodule

/* File: core/lsr_params.svh */
/*
  Constants for the line status readback block: register indices, field
  positions, reset values and counts. Definitions only; included by name.
*/
`ifndef LSR_PARAMS_SVH
`define LSR_PARAMS_SVH

// register indices; byte address is four times the index
`define LSR_IDX_NOISE_MARGIN 4'h2
`define LSR_IDX_COEF_LOW 4'h3
`define LSR_IDX_COEF_HIGH 4'h4
`define LSR_IDX_TRAIN_SUBSTATE 4'h5
`define LSR_IDX_GAIN_STATE 4'h6
`define LSR_IDX_COEF_SELECT 4'h3
`define LSR_IDX_CONTROL 4'h8

// reset values
`define LSR_RST_COEF_SELECT 8'h00
`define LSR_RST_CONTROL 8'h00
`define LSR_RST_BYTE 8'h00
`define LSR_RST_WORD 16'h0000

// control register field
`define LSR_CTRL_RT_MODE 0

// combined gain register field positions
`define LSR_GS_ST2 7
`define LSR_GS_ST1 6
`define LSR_GS_DG_HI 5
`define LSR_GS_DG_LO 4
`define LSR_GS_ST0 3
`define LSR_GS_AG_HI 2
`define LSR_GS_AG_LO 0

// noise margin reload interval in baud intervals
`define LSR_NM_BAUDS 64

// substate codes
`define LSR_SUB_NONE 4'h0
`define LSR_SUB_1 4'h1
`define LSR_SUB_2 4'h2
`define LSR_SUB_3 4'h3
`define LSR_SUB_4 4'h4
`define LSR_SUB_5 4'h5
`define LSR_SUB_6 4'h6
`define LSR_SUB_7 4'h7
`define LSR_SUB_8 4'h8

`endif

/* File: core/lsr_pkg.sv */
/*
  Types for the line status readback block: activation states, training
  phases and the bus slave state machine.
  Assumes lsr_params.svh sits beside it for the numeric constants.
*/
package lsr_pkg;

  // three-bit activation state of the activation machine
  typedef enum logic [2:0] {
    LSR_ACT_INACTIVE = 3'h0,
    LSR_ACT_ACTIVATING = 3'h1,
    LSR_ACT_ACTIVE_RUN = 3'h2,
    LSR_ACT_ACTIVE_EXP = 3'h3,
    LSR_ACT_PEND_DEACT = 3'h4,
    LSR_ACT_DEACTIVATED = 3'h5,
    LSR_ACT_UNUSED6 = 3'h6,
    LSR_ACT_UNUSED7 = 3'h7
  } lsr_act_state_t;

  // training phase reported by the activation machine
  typedef enum logic [3:0] {
    LSR_PH_NONE = 4'h0,
    LSR_PH_WAIT = 4'h1,
    LSR_PH_PRE_GAIN = 4'h2,
    LSR_PH_PRE_ECHO_CANCEL = 4'h3,
    LSR_PH_SIGNAL_DETECT = 4'h4,
    LSR_PH_GAIN_ADAPT = 4'h5,
    LSR_PH_ECHO_CANCEL = 4'h6,
    LSR_PH_FIRST_LOCK = 4'h7,
    LSR_PH_SECOND_LOCK = 4'h8,
    LSR_PH_FOUR_LEVEL_DETECT = 4'h9,
    LSR_PH_FRAME_DETECT = 4'hA
  } lsr_phase_t;

  // bus slave states, gray along idle -> ack
  typedef enum logic [1:0] {
    LSR_BUS_IDLE = 2'b00,
    LSR_BUS_ACK = 2'b01
  } lsr_bus_state_t;

endpackage

/* File: core/lsr_coef_if.sv */
/*
  Carrier between the register front and the coefficient capture store.
  Assumes both ends run on core_clk.
*/
`timescale 1ns/1ps
interface lsr_coef_if;
  logic capture;
  logic [15:0] word_in;
  logic low_read;
  logic [7:0] low_byte;
  logic [7:0] high_byte;

  modport front
  (
    output capture,
    output word_in,
    output low_read,
    input low_byte,
    input high_byte
  );

  modport store
  (
    input capture,
    input word_in,
    input low_read,
    output low_byte,
    output high_byte
  );
endinterface

/* File: core/lsr_coef_store.sv */
/*
  Coefficient word store: captures the selected coefficient word on each
  receive symbol clock rising edge and keeps a high-byte snapshot taken when the
  low byte is read, so both bytes come from one capture.
  Assumes capture and low_read are one-cycle pulses on core_clk.
*/
`timescale 1ns/1ps
`include "lsr_params.svh"
module lsr_coef_store
(
  input wire logic core_clk,
  input wire logic sys_rst,
  lsr_coef_if.store cif
);
  import lsr_pkg::*;

  logic [15:0] word_reg;
  logic [15:0] word_next;
  logic [7:0] high_hold_reg;
  logic [7:0] high_hold_next;

  // capture and snapshot; a capture in the same cycle as a low read
  // does not disturb the snapshot, which takes the older word
  always_comb
  begin
    word_next = word_reg;
    high_hold_next = high_hold_reg;
    if (cif.low_read)
    begin
      high_hold_next = word_reg[15:8];
    end
    if (cif.capture)
    begin
      word_next = cif.word_in;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      word_reg <= `LSR_RST_WORD;
      high_hold_reg <= `LSR_RST_BYTE;
    end
    else
    begin
      word_reg <= word_next;
      high_hold_reg <= high_hold_next;
    end
  end

  // read data straight from registers
  assign cif.low_byte = word_reg[7:0];
  assign cif.high_byte = high_hold_reg;
endmodule

/* File: sim/lsr_top_sva.sv */
/*
  Checker for lsr_top: bus answer, config writes and status read data.
  Assumes it is bound to lsr_top; one clock, synchronous reset.
*/
`timescale 1ns/1ps
module lsr_top_sva
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] coefficient_select,
  input wire lsr_pkg::lsr_act_state_t act_state,
  input wire logic [1:0] digital_gain_setting,
  input wire logic [2:0] analog_gain_step,
  input wire logic rt_mode
);
  import lsr_pkg::*;
  logic tk;
  logic d0;
  logic [3:0] ix;
  logic [7:0] db;
  logic [7:0] gx;
  // taken request, index, write byte, expected combined byte
  assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign ix = wb_adr_i[5:2];
  assign db = wb_dat_i[7:0];
  assign d0 = wb_dat_i[0];
  assign gx = {act_state[2:1], digital_gain_setting, act_state[0], analog_gain_step};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_rd(logic [3:0] i);
    tk && !wb_we_i && ix == i;
  endsequence
  sequence s_wr(logic [3:0] i);
    tk && wb_we_i && wb_sel_i[0] && ix == i;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack;
    tk |=> s_ans;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single cycle");
  property p_sel_wr;
    s_wr(4'h3) |=> coefficient_select == $past(db);
  endproperty
  a_sel_wr: assert property (p_sel_wr) else $error("select not written");
  property p_mode_wr;
    s_wr(4'h8) |=> rt_mode == $past(d0);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode not written");
  property p_sel_hold;
    !(tk && wb_we_i && wb_sel_i[0] && ix == 4'h3) |=> $stable(coefficient_select);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select moved");
  property p_dat_hold;
    !(tk && !wb_we_i) |=> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_unmap;
    tk && !wb_we_i && ix inside {4'h0, 4'h1, 4'h7, [4'h9:4'hF]} |=> wb_dat_o == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_gain;
    s_rd(4'h6) ##0 !$past(sys_rst) |=> wb_dat_o == {24'h0, $past(gx, 2)};
  endproperty
  a_gain: assert property (p_gain) else $error("combined byte wrong");
  property p_sub_off;
    s_rd(4'h5) ##0 !$past(sys_rst) && $past(act_state) != LSR_ACT_ACTIVATING |=> wb_dat_o == 32'h0;
  endproperty
  a_sub_off: assert property (p_sub_off) else $error("substate not zero");
endmodule

/* File: sim/tb_line_status_readback.sv */
/*
  Self-checking bench for lsr_top, random and corner traffic.
  Assumes core files and lsr_top_sva compiled first.
*/
`timescale 1ns/1ps
module tb_line_status_readback;
  import lsr_pkg::*;
  logic core_clk, sys_rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic baud_tick, receive_symbol_clock, rt_mode;
  logic [5:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, r;
  logic [3:0] wb_sel_i;
  logic [7:0] noise_margin_calc, coefficient_select;
  logic [7:0] nm [3] = '{8'h35, 8'hF4, 8'h00};
  logic [15:0] coef_word_in, w;
  lsr_act_state_t act_state;
  lsr_phase_t train_phase;
  logic [1:0] digital_gain_setting;
  logic [2:0] analog_gain_step;
  int n_errors, comparisons, seed, k, m, a, p;

  lsr_top #(.NM_BAUDS(4)) uut
  (
    .core_clk, .sys_rst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .baud_tick, .noise_margin_calc, .receive_symbol_clock, .coef_word_in,
    .coefficient_select, .act_state, .train_phase, .digital_gain_setting, .analog_gain_step, .rt_mode
  );

  // 200 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic close_out();
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one classic cycle; bounded wait so a dead slave cannot hang us
  task automatic wb(input logic [3:0] idx, input logic we, input logic [7:0] d);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= {idx, 2'h0};
    wb_we_i <= we;
    wb_dat_i <= {24'h0, d};
    for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++)
      @(posedge core_clk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
    if (i == 20)
    begin
      n_errors++;
      close_out();
    end
  endtask

  task automatic rdc(input logic [3:0] idx, input logic [7:0] e, input string n);
    wb(idx, 1'b0, 8'h00);
    check(n, q, {24'h0, e});
  endtask

  task automatic tick(input int n);
    repeat (n)
    begin
      baud_tick <= 1'b1;
      @(posedge core_clk);
      baud_tick <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  task automatic rclk();
    receive_symbol_clock <= 1'b1;
    repeat (2) @(posedge core_clk);
    receive_symbol_clock <= 1'b0;
    @(posedge core_clk);
  endtask

  // substate nibble per phase, packed lowest phase first
  function automatic logic [7:0] f_sub(input int m, input int a, input int p);
    logic [43:0] t;
    t = m ? 44'h76543200010 : 44'h87665432100;
    return (a == 1) ? {4'h0, t[p*4 +: 4]} : 8'h00;
  endfunction

  // main sequence
  initial
  begin
    {sys_rst, wb_we_i, wb_cyc_i, wb_stb_i, baud_tick, receive_symbol_clock} = 6'h20;
    {wb_adr_i, wb_dat_i, noise_margin_calc, coef_word_in} = '0;
    {digital_gain_setting, analog_gain_step} = 5'h00;
    act_state = LSR_ACT_INACTIVE;
    train_phase = LSR_PH_NONE;
    wb_sel_i = 4'hF;
    n_errors = 0;
    comparisons = 0;
    seed = 50;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (k = 0; k < 16; k++)
      rdc(k[3:0], 8'h00, "reset read");
    // reload only on each fourth tick; reads between change nothing
    for (k = 0; k < 3; k++)
    begin
      noise_margin_calc <= nm[k];
      tick(3);
      rdc(4'h2, k ? nm[k-1] : 8'h00, "margin hold");
      tick(1);
      rdc(4'h2, nm[k], "margin load");
    end
    // random selects; a write without lane 0 is dropped
    repeat (4)
    begin
      r = $random(seed);
      wb(4'h3, 1'b1, r[7:0]);
      check("select", 32'(coefficient_select), 32'(r[7:0]));
      wb_sel_i <= 4'hE;
      wb(4'h3, 1'b1, ~r[7:0]);
      check("select lane", 32'(coefficient_select), 32'(r[7:0]));
      wb_sel_i <= 4'hF;
    end
    // high byte must stay with the low byte read across a capture
    repeat (4)
    begin
      w = 16'($random(seed));
      coef_word_in <= w;
      rclk();
      coef_word_in <= ~w;
      rdc(4'h3, w[7:0], "coef low");
      rclk();
      coef_word_in <= w;
      rdc(4'h4, w[15:8], "coef pair");
      rdc(4'h3, ~w[7:0], "coef edge");
      wb(4'h4, 1'b1, w[7:0]);
      rdc(4'h4, ~w[15:8], "coef high");
    end
    // every mode, state and phase with random gains
    for (m = 0; m < 2; m++)
    begin
      wb(4'h8, 1'b1, m[7:0]);
      check("mode", 32'(rt_mode), 32'(m));
      rdc(4'h8, m[7:0], "control");
      for (a = 0; a < 8; a++)
        for (p = 0; p < 11; p++)
        begin
          r = $random(seed);
          act_state <= lsr_act_state_t'(a);
          train_phase <= lsr_phase_t'(p);
          digital_gain_setting <= r[1:0];
          analog_gain_step <= r[4:2];
          @(posedge core_clk);
          rdc(4'h5, f_sub(m, a, p), "substate");
          wb(4'h6, 1'b1, r[15:8]);
          rdc(4'h6, {a[2], a[1], r[1:0], a[0], r[4:2]}, "gain");
        end
    end
    close_out();
  end
endmodule

bind lsr_top lsr_top_sva u_sva
(
  .core_clk, .sys_rst, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .coefficient_select, .act_state, .digital_gain_setting, .analog_gain_step, .rt_mode
);
